// [include/fpd_map.svh]
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH

// ****************************************************************
// timing
// ****************************************************************
`define FPD_CLK_NS         10
`define FPD_STARTUP_MS     2000
`define FPD_STARTUP_CYCLES (`FPD_STARTUP_MS * (1000000 / `FPD_CLK_NS))
`define FPD_DEBOUNCE_MS    10
`define FPD_DEBOUNCE_CYCLES (`FPD_DEBOUNCE_MS * (1000000 / `FPD_CLK_NS))
`define FPD_DIGIT_US       1000
`define FPD_DIGIT_CYCLES   (`FPD_DIGIT_US * (1000 / `FPD_CLK_NS))

// ****************************************************************
// display layout and item classes
// ****************************************************************
`define FPD_NUM_DIGITS     5
`define FPD_NUM_ITEMS      16
`define FPD_ITEM_SPEED     4'h1
`define FPD_WIDE_MASK      16'h000d
`define FPD_WP_GROUPS_ON   16'h000c
`define FPD_SEG_MINUS      7'h40
`define FPD_SEG_BLANK      7'h00

`endif

// [include/fpd_pkg.sv]
// ****************************************************************
// panel types
// ****************************************************************
package fpd_pkg;

  // display modes, one-hot
  typedef enum logic [6:0] {
    FPD_STATUS = 7'h01,
    FPD_DIAG   = 7'h02,
    FPD_ALARM  = 7'h04,
    FPD_BASIC  = 7'h08,
    FPD_GAIN   = 7'h10,
    FPD_EXT    = 7'h20,
    FPD_IO     = 7'h40
  } fpd_mode_e;

  typedef logic [3:0] fpd_item_t;

endpackage

// [core/fpd_debounce.sv]
`timescale 1ns/1ps
`include "fpd_map.svh"
// ****************************************************************
// one pushbutton: stability filter and press-edge pulse
// ****************************************************************
module fpd_debounce #(
  parameter int DB_CYCLES = `FPD_DEBOUNCE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic btn_raw,
  output logic      press
);
  logic [19:0] cnt_q;     // cycles the raw level differs from stable
  logic        stable_q;  // accepted level
  wire         differs = btn_raw != stable_q;
  wire         settled = cnt_q == 20'(DB_CYCLES - 1);

  // accept a new level only after it held for the whole window;
  // bounces restart the window, so chatter never reaches stable_q
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q    <= 20'h00000;
      stable_q <= 1'b0;
      press    <= 1'b0;
    end else begin
      cnt_q    <= (differs && !settled) ? cnt_q + 20'h00001 : 20'h00000;
      if (differs && settled) begin
        stable_q <= btn_raw;
      end
      press    <= differs && settled && btn_raw;
    end
  end

  // a press is one cycle long, holding never repeats it
  a_press_single: assert property (@(posedge clk_sys) disable iff (srst)
    press |=> !press)
    else $error("press pulse longer than one cycle");
endmodule

// [core/fpd_panel.sv]
`timescale 1ns/1ps
`include "fpd_map.svh"
// ****************************************************************
// front panel: buttons, mode sequence, status item, led scan
// ****************************************************************
module fpd_panel
  import fpd_pkg::*;
#(
  parameter int STARTUP_CYCLES = `FPD_STARTUP_CYCLES,
  parameter int DB_CYCLES      = `FPD_DEBOUNCE_CYCLES,
  parameter int DIGIT_CYCLES   = `FPD_DIGIT_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        btn_mode,
  input  wire logic        btn_up,
  input  wire logic        btn_down,
  input  wire logic        btn_set,
  input  wire logic [15:0] parameter_write_protect_setting,
  input  wire logic [3:0]  startup_status_item_select,
  input  wire logic [31:0] item_bcd,
  input  wire logic        item_neg,
  output fpd_mode_e        disp_mode_q,
  output fpd_item_t        item_sel_q,
  output logic             show_value_q,
  output logic [6:0]       seg_q,
  output logic             dp_q,
  output logic [4:0]       digit_en_q
);

  // ****************************************************************
  // pushbuttons
  // ****************************************************************
  logic press_mode;   // one-cycle press pulses
  logic press_up;
  logic press_down;
  logic press_set;

  fpd_debounce #(.DB_CYCLES(DB_CYCLES)) u_db_mode (
    .clk_sys (clk_sys),
    .srst    (srst),
    .btn_raw (btn_mode),
    .press   (press_mode)
  );
  fpd_debounce #(.DB_CYCLES(DB_CYCLES)) u_db_up (
    .clk_sys (clk_sys),
    .srst    (srst),
    .btn_raw (btn_up),
    .press   (press_up)
  );
  fpd_debounce #(.DB_CYCLES(DB_CYCLES)) u_db_down (
    .clk_sys (clk_sys),
    .srst    (srst),
    .btn_raw (btn_down),
    .press   (press_down)
  );
  fpd_debounce #(.DB_CYCLES(DB_CYCLES)) u_db_set (
    .clk_sys (clk_sys),
    .srst    (srst),
    .btn_raw (btn_set),
    .press   (press_set)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // next display mode; the three protected groups are skipped unless grp_en is set
  function automatic fpd_mode_e next_mode(input fpd_mode_e m, input logic grp_en);
    case (m)
      FPD_STATUS: next_mode = FPD_DIAG;
      FPD_DIAG:   next_mode = FPD_ALARM;
      FPD_ALARM:  next_mode = FPD_BASIC;
      FPD_BASIC:  next_mode = grp_en ? FPD_GAIN : FPD_STATUS;
      FPD_GAIN:   next_mode = grp_en ? FPD_EXT : FPD_STATUS;
      FPD_EXT:    next_mode = grp_en ? FPD_IO : FPD_STATUS;
      default:    next_mode = FPD_STATUS;
    endcase
  endfunction

  // seven-segment pattern (gfedcba) of one hex nibble
  function automatic logic [6:0] seg_hex(input logic [3:0] n);
    case (n)
      4'h0: seg_hex = 7'h3f;
      4'h1: seg_hex = 7'h06;
      4'h2: seg_hex = 7'h5b;
      4'h3: seg_hex = 7'h4f;
      4'h4: seg_hex = 7'h66;
      4'h5: seg_hex = 7'h6d;
      4'h6: seg_hex = 7'h7d;
      4'h7: seg_hex = 7'h07;
      4'h8: seg_hex = 7'h7f;
      4'h9: seg_hex = 7'h6f;
      4'ha: seg_hex = 7'h77;
      4'hb: seg_hex = 7'h7c;
      4'hc: seg_hex = 7'h39;
      4'hd: seg_hex = 7'h5e;
      4'he: seg_hex = 7'h79;
      default: seg_hex = 7'h71;
    endcase
  endfunction

  // number of a one-hot mode, shown as a glyph on the left digit;
  // an explicit table keeps the decode free of log arithmetic
  function automatic logic [3:0] mode_num(input fpd_mode_e m);
    case (m)
      FPD_STATUS: mode_num = 4'h0;
      FPD_DIAG:   mode_num = 4'h1;
      FPD_ALARM:  mode_num = 4'h2;
      FPD_BASIC:  mode_num = 4'h3;
      FPD_GAIN:   mode_num = 4'h4;
      FPD_EXT:    mode_num = 4'h5;
      FPD_IO:     mode_num = 4'h6;
      default:    mode_num = 4'h0;
    endcase
  endfunction

  // ****************************************************************
  // mode and status item state
  // ****************************************************************
  logic        init_q;      // startup item not yet captured
  logic        boot_q;      // power-on symbol phase running
  logic [27:0] boot_cnt_q;  // power-on symbol timer

  wire grp_en    = parameter_write_protect_setting == `FPD_WP_GROUPS_ON;
  wire in_status = disp_mode_q == FPD_STATUS;
  // mode press wins over the others in the same cycle
  wire do_step   = in_status && !press_mode && !boot_q && (press_up || press_down);
  wire do_set    = in_status && !press_mode && !boot_q && !do_step && press_set && !show_value_q;
  wire boot_done = boot_q && boot_cnt_q == 28'(STARTUP_CYCLES - 1);

  // strap-like capture of the startup item one cycle after release,
  // since a synchronous reset may only load constants
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      init_q     <= 1'b1;
      boot_q     <= 1'b0;
      boot_cnt_q <= 28'h0000000;
    end else begin
      init_q     <= 1'b0;
      if (init_q) begin
        boot_q <= 1'b1;
      end else if (boot_done) begin
        boot_q <= 1'b0;
      end
      boot_cnt_q <= boot_q ? boot_cnt_q + 28'h0000001 : 28'h0000000;
    end
  end

  // mode sequence, item selection and symbol/value choice
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      disp_mode_q  <= FPD_STATUS;
      item_sel_q   <= 4'h0;
      show_value_q <= 1'b0;
    end else if (init_q) begin
      item_sel_q   <= startup_status_item_select;
      show_value_q <= 1'b0;
    end else if (boot_done) begin
      show_value_q <= 1'b1;
    end else if (press_mode && !boot_q) begin
      disp_mode_q  <= next_mode(disp_mode_q, grp_en);
      show_value_q <= 1'b0;
    end else if (do_step) begin
      // 4-bit index wraps through all sixteen items
      item_sel_q   <= press_up ? item_sel_q + 4'h1 : item_sel_q - 4'h1;
      show_value_q <= 1'b0;
    end else if (do_set) begin
      show_value_q <= 1'b1;
    end
  end

  // ****************************************************************
  // led scan
  // ****************************************************************
  logic [16:0] scan_cnt_q;  // digit dwell divider
  logic [2:0]  cur_dig_q;   // digit being loaded, 0 is rightmost

  wire scan_en = scan_cnt_q == 17'(DIGIT_CYCLES - 1);

  // a digit advances once per dwell period
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scan_cnt_q <= 17'h00000;
      cur_dig_q  <= 3'h0;
    end else begin
      scan_cnt_q <= scan_en ? 17'h00000 : scan_cnt_q + 17'h00001;
      if (scan_en) begin
        cur_dig_q <= (cur_dig_q == 3'(`FPD_NUM_DIGITS - 1)) ? 3'h0 : cur_dig_q + 3'h1;
      end
    end
  end

  // digit content; only the five low bcd digits are ever selected
  wire [3:0] nib       = item_bcd[{cur_dig_q[1:0], 2'b00} +: 4] ;
  wire [3:0] nib_top   = item_bcd[19:16];
  wire [3:0] cur_nib   = cur_dig_q[2] ? nib_top : nib;
  wire       is_speed  = item_sel_q == `FPD_ITEM_SPEED;
  wire [15:0] wide_mask = `FPD_WIDE_MASK;  // one bit per item, set for wide counters
  wire       is_wide   = wide_mask[item_sel_q];
  wire       val_on    = in_status && show_value_q;
  wire       sym_on    = in_status && !show_value_q;
  wire       minus_on  = val_on && is_speed && item_neg && cur_dig_q == 3'h4;
  wire       point_on  = val_on && is_wide && item_neg && cur_dig_q != 3'h0;
  wire [6:0] mode_sym  = seg_hex(mode_num(disp_mode_q));
  wire [6:0] seg_d     = minus_on ? `FPD_SEG_MINUS :
                         val_on ? seg_hex(cur_nib) :
                         sym_on ? (cur_dig_q == 3'h4 ? seg_hex(item_sel_q) : `FPD_SEG_BLANK) :
                         (cur_dig_q == 3'h4 ? mode_sym : `FPD_SEG_BLANK);

  // outputs change only on a digit boundary, avoiding ghosting
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seg_q      <= `FPD_SEG_BLANK;
      dp_q       <= 1'b0;
      digit_en_q <= 5'h00;
    end else if (scan_en) begin
      seg_q      <= seg_d;
      dp_q       <= point_on;
      digit_en_q <= 5'h01 << cur_dig_q;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_mode_advance: assert property (press_mode && !boot_q && !init_q && !boot_done
    |=> disp_mode_q == next_mode($past(disp_mode_q), $past(grp_en)))
    else $error("mode press did not advance mode");
  a_item_up: assert property (do_step && press_up && !init_q && !boot_done
    |=> item_sel_q == $past(item_sel_q) + 4'h1)
    else $error("up press did not step item forward");
  a_item_down: assert property (do_step && !press_up && !init_q && !boot_done
    |=> item_sel_q == $past(item_sel_q) - 4'h1)
    else $error("down press did not step item back");
  a_select_symbol: assert property (do_step && !init_q && !boot_done
    |=> !show_value_q ##1 (!show_value_q || $past(press_set)))
    else $error("new item did not show symbol");
  a_set_value: assert property (do_set && !init_q && !boot_done |=> show_value_q)
    else $error("set press did not show value");
  a_boot_hold: assert property ($rose(boot_q) |-> !show_value_q [*8])
    else $error("value shown during power-on symbol");
  a_boot_end: assert property (boot_done |=> show_value_q && !boot_q ##1 !boot_q)
    else $error("power-on symbol did not end in value");
  a_minus_seg: assert property (scan_en && minus_on |=> seg_q == `FPD_SEG_MINUS && digit_en_q == 5'h10)
    else $error("reverse speed minus missing");
  a_neg_points: assert property (scan_en && val_on && is_wide && item_neg |=> dp_q == !digit_en_q[0])
    else $error("negative counter points wrong");
  a_group_gate: assert property (!grp_en && disp_mode_q == FPD_BASIC && press_mode && !boot_q
    |=> disp_mode_q == FPD_STATUS)
    else $error("protected group reached");
  a_scan_onehot: assert property (scan_en |=> $onehot(digit_en_q))
    else $error("digit enable not one-hot");

  c_boot_done: cover property (boot_done ##1 show_value_q);
  c_item_value: cover property (do_step ##[1:1000] do_set);
  c_group_mode: cover property (disp_mode_q == FPD_IO);
  c_minus: cover property (scan_en && minus_on);
endmodule

// [verification/fpd_operator_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// operator at the panel: presses and releases pushbuttons
// ****************************************************************
module fpd_operator_model #(
  parameter int DB_CYCLES = 4
) (
  input  wire logic clk_sys,
  output logic      btn_mode,
  output logic      btn_up,
  output logic      btn_down,
  output logic      btn_set
);
  logic [3:0] btn_q;  // held buttons: set, down, up, mode
  // an open switch reads low, so released buttons sit at 0
  initial btn_q = 4'h0;
  assign {btn_set, btn_down, btn_up, btn_mode} = btn_q;
  // hold, then stay released long enough for the filter to see it
  task automatic press(input logic [3:0] mask, input int hold);
    @(posedge clk_sys);
    btn_q <= mask;
    repeat (hold) @(posedge clk_sys);
    btn_q <= 4'h0;
    repeat (2 * DB_CYCLES + 2) @(posedge clk_sys);
  endtask
endmodule

// [verification/front_panel_display_ui_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ****************************************************************
// panel bench: short counts so the boot phase fits the run
// ****************************************************************
module front_panel_display_ui_tb_top import fpd_pkg::*;;
  localparam int STARTUP = 50;  // boot symbol phase
  localparam int DB      = 4;   // debounce length
  localparam int DIGIT   = 3;   // digit dwell
  logic             clk_sys;
  logic             srst;
  logic [15:0]      wp_setting;  // write-protect setting
  logic [3:0]       start_sel;   // startup item
  logic [31:0]      item_bcd;
  logic             item_neg;
  logic             btn_mode, btn_up, btn_down, btn_set;
  fpd_mode_e        disp_mode_q;
  fpd_item_t        item_sel_q;
  logic             show_value_q, dp_q;
  logic [6:0]       seg_q;
  logic [4:0]       digit_en_q;
  int               errors, comparisons, cyc;
  fpd_mode_e        seq_off[4] = '{FPD_DIAG, FPD_ALARM, FPD_BASIC, FPD_STATUS};
  fpd_mode_e        seq_on[7]  = '{FPD_DIAG, FPD_ALARM, FPD_BASIC, FPD_GAIN, FPD_EXT, FPD_IO, FPD_STATUS};
  // hex glyphs of the five low digits 12345, digit 0 first
  logic [6:0]       glyph_val[5] = '{7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06};

  fpd_panel #(.STARTUP_CYCLES(STARTUP), .DB_CYCLES(DB), .DIGIT_CYCLES(DIGIT)) uut (
    .clk_sys(clk_sys), .srst(srst), .btn_mode(btn_mode), .btn_up(btn_up), .btn_down(btn_down),
    .btn_set(btn_set), .parameter_write_protect_setting(wp_setting), .startup_status_item_select(start_sel),
    .item_bcd(item_bcd), .item_neg(item_neg), .disp_mode_q(disp_mode_q), .item_sel_q(item_sel_q),
    .show_value_q(show_value_q), .seg_q(seg_q), .dp_q(dp_q), .digit_en_q(digit_en_q));
  fpd_operator_model #(.DB_CYCLES(DB)) op (
    .clk_sys(clk_sys), .btn_mode(btn_mode), .btn_up(btn_up), .btn_down(btn_down), .btn_set(btn_set));

  // ****************************************************************
  // clock and cycle count
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // wait, bounded, until digit d is lit; a dead scan ends the run
  task automatic seek(input int d);
    int n;
    n = 0;
    while (digit_en_q !== 5'(1 << d)) begin
      @(posedge clk_sys); #1;
      n++;
      if (n > 40) begin
        errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, digit_en_q, 5'(1 << d));
        finish_test();
      end
    end
  endtask

  // boot: startup item symbol, buttons ignored, value after the phase
  task automatic t_boot();
    int t0;
    `CHK(digit_en_q, 5'h00)
    @(posedge clk_sys);
    srst <= 1'b0;
    t0 = cyc;
    repeat (2) @(posedge clk_sys); #1;
    `CHK(item_sel_q, 4'h3)
    op.press(4'b0010, 2 * DB);
    #1;
    `CHK(item_sel_q, 4'h3)
    `CHK(show_value_q, 1'b0)
    // symbol of startup item 3 on the left digit during the phase
    seek(4);
    `CHK(seg_q, 7'h4f)
    while (show_value_q !== 1'b1 && cyc - t0 < 2 * STARTUP) begin
      @(posedge clk_sys); #1;
    end
    `CHK((cyc - t0 >= STARTUP - 2) && (cyc - t0 <= STARTUP + 3), 1'b1)
    if (show_value_q !== 1'b1) begin
      finish_test();
    end
  endtask

  // negative wide counter: points on the upper four digits, scan order
  task automatic t_wide();
    for (int d = 0; d < 5; d++) begin
      seek(d);
      `CHK(dp_q, d != 0)
      `CHK(seg_q, glyph_val[d])
      repeat (DIGIT) @(posedge clk_sys); #1;
      `CHK(digit_en_q, 5'(1 << ((d + 1) % 5)))
    end
  endtask

  // item stepping, symbol then value, sign of speed, one step per hold
  task automatic t_nav();
    op.press(4'b0100, 2 * DB);
    op.press(4'b0100, 2 * DB); #1;
    `CHK(item_sel_q, 4'h1)
    `CHK(show_value_q, 1'b0)
    seek(0);
    `CHK(seg_q, 7'h00)
    seek(4);
    `CHK(seg_q, 7'h06)
    op.press(4'b1000, 2 * DB); #1;
    `CHK(show_value_q, 1'b1)
    seek(4);
    `CHK(seg_q, 7'h40)
    @(posedge clk_sys);
    item_neg <= 1'b0;
    repeat (5 * DIGIT + 2) @(posedge clk_sys);
    #1;
    seek(4);
    `CHK(seg_q, 7'h06)
    op.press(4'b0010, 10 * DB); #1;
    `CHK(item_sel_q, 4'h2)
    op.press(4'b0100, 2 * DB);
    op.press(4'b0100, 2 * DB);
    op.press(4'b0100, 2 * DB); #1;
    `CHK(item_sel_q, 4'hf)
    op.press(4'b0110, 2 * DB); #1;
    `CHK(item_sel_q, 4'h0)
  endtask

  // mode cycle with groups locked, then unlocked; up refused off status
  task automatic t_modes();
    foreach (seq_off[i]) begin
      op.press(4'b0001, 2 * DB); #1;
      `CHK(disp_mode_q, seq_off[i])
      if (i == 0) begin
        op.press(4'b0010, 2 * DB); #1;
        `CHK(item_sel_q, 4'h0)
        seek(4);
        `CHK(seg_q, 7'h06)
      end
    end
    @(posedge clk_sys);
    wp_setting <= 16'h000c;
    foreach (seq_on[i]) begin
      op.press(4'b0001, 2 * DB); #1;
      `CHK(disp_mode_q, seq_on[i])
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    errors = 0;
    comparisons = 0;
    srst = 1'b1;
    wp_setting = 16'h0000;
    start_sel = 4'h3;
    // upper digits set so that only the five low ones may show
    item_bcd = 32'h98712345;
    item_neg = 1'b1;
    @(posedge clk_sys); #1;
    `CHK(disp_mode_q, FPD_STATUS)
    t_boot();
    t_wide();
    t_nav();
    t_modes();
    finish_test();
  end
endmodule
